// File: verilog/psceh_core.sv
// Operation
// - A power control write moving a function to D1 or D3 raises the power-change request.
// - The request stays high until the acknowledge is seen.
// - While the request is high, every pending configuration completion is withheld.
// - While the request is high, the targeted function number is driven on the target output.
// - On acknowledge, the PF or VF power state output takes the function's new state.
// - The downstream port id input appears as the port number field of Link Capabilities.
// - That pulse sets the corrected internal error bit of every enabled function.
// - That pulse also requests an error message, only while messages are enabled.
// - In endpoint mode an unmasked correctable error pulses the error output for one cycle.
// - The error output is the registered OR over the device status set terms of all functions, in endpoint mode only.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "psceh_cfg.svh"
module psceh_core #(
  parameter int NF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Power management control write
  input wire logic pmw_valid,
  output logic pmw_ready,
  input wire logic [7:0] pmw_func,
  input wire logic pmw_is_vf,
  input wire psceh_pkg::psceh_dstate_t pmw_dstate,
  // Power-change handshake
  output logic pm_change_req,
  input wire logic pm_change_ack,
  output logic [7:0] pm_target_func,
  output logic [2*NF-1:0] pf_dstate_out,
  output psceh_pkg::psceh_dstate_t vf_dstate_out,
  // Completion path
  input wire logic cpl_in_valid,
  output logic cpl_in_ready,
  output logic cpl_out_valid,
  input wire logic cpl_out_ready,
  // Port number
  input wire logic [7:0] downstream_port_id_in,
  // Correctable error
  input wire logic cor_err_in,
  output logic cor_err_out,
  output logic cor_msg_req
);
  import psceh_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic msg_en;
    logic ep;
    logic rep;
    logic [NF-1:0] fen;
    logic [1:0] ist;
    logic [1:0] imask;
    logic [7:0] port;
    logic req_d;
  } psceh_core_state_t;

  psceh_core_state_t c_reg;
  psceh_core_state_t c_next;
  logic req;
  logic wr_acc;
  logic [31:0] wmask;
  logic [31:0] w1c;
  logic [31:0] rmux;
  logic [NF-1:0] aer_clr;
  logic [NF-1:0] dev_clr;
  logic [NF-1:0] aer_stat;
  logic [NF-1:0] dev_stat;
  logic cor_event;
  logic [1:0] ev_set;

  // Byte lanes to bit mask
  function automatic logic [31:0] lane_mask(logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++)
    begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  // Write hit on a register
  function automatic logic hit(logic [5:0] a, logic [5:0] off, logic acc);
    return acc && (a == off);
  endfunction : hit

  // Control word as read back
  function automatic logic [31:0] ctrl_word(psceh_core_state_t s);
    logic [31:0] v;
    v = '0;
    v[`PSCEH_CTRL_MSG_EN] = s.msg_en;
    v[`PSCEH_CTRL_EP] = s.ep;
    v[`PSCEH_CTRL_REP] = s.rep;
    v[`PSCEH_CTRL_FEN_LSB +: NF] = s.fen;
    return v;
  endfunction : ctrl_word

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !c_reg.ack;
  assign wr_acc = avs_write && c_reg.ack;
  assign wmask = lane_mask(avs_byteenable);
  assign w1c = avs_writedata & wmask;
  assign avs_readdata = c_reg.rdata;
  assign irq = |(c_reg.ist & c_reg.imask);

  // Clear strobes into the error status
  assign aer_clr = hit(avs_address, `PSCEH_OFF_AER, wr_acc) ? w1c[NF-1:0] : '0;
  assign dev_clr = hit(avs_address, `PSCEH_OFF_DSTAT, wr_acc) ? w1c[NF-1:0] : '0;

  // Events for the sticky status
  always_comb
  begin
    ev_set = '0;
    ev_set[`PSCEH_IRQ_PM] = pm_change_req && !c_reg.req_d;
    ev_set[`PSCEH_IRQ_COR] = cor_event;
  end

  // Read multiplexer
  always_comb
  begin
    rmux = '0;
    unique case (avs_address)
      `PSCEH_OFF_CTRL:
      begin
        rmux = ctrl_word(c_reg);
      end
      `PSCEH_OFF_ISTAT:
      begin
        rmux[1:0] = c_reg.ist;
      end
      `PSCEH_OFF_IMASK:
      begin
        rmux[1:0] = c_reg.imask;
      end
      `PSCEH_OFF_AER:
      begin
        rmux[NF-1:0] = aer_stat;
      end
      `PSCEH_OFF_DSTAT:
      begin
        rmux[NF-1:0] = dev_stat;
      end
      `PSCEH_OFF_PM:
      begin
        rmux[`PSCEH_PM_BUSY] = pm_change_req;
        rmux[`PSCEH_PM_VF_LSB +: 2] = vf_dstate_out;
        rmux[`PSCEH_PM_TGT_LSB +: 8] = pm_target_func;
        rmux[`PSCEH_PM_PF_LSB +: 2*NF] = pf_dstate_out;
      end
      `PSCEH_OFF_LCAP:
      begin
        rmux[`PSCEH_LCAP_PORT_LSB +: 8] = c_reg.port;
      end
      default:
      begin
        rmux = '0;
      end
    endcase
  end

  // Next state
  always_comb
  begin
    logic [31:0] m;
    m = '0;
    c_next = c_reg;
    c_next.ack = req && !c_reg.ack;
    if (avs_read && !c_reg.ack)
    begin
      c_next.rdata = rmux;
    end
    c_next.port = downstream_port_id_in;
    c_next.req_d = pm_change_req;
    if (hit(avs_address, `PSCEH_OFF_CTRL, wr_acc))
    begin
      m = (ctrl_word(c_reg) & ~wmask) | w1c;
      c_next.msg_en = m[`PSCEH_CTRL_MSG_EN];
      c_next.ep = m[`PSCEH_CTRL_EP];
      c_next.rep = m[`PSCEH_CTRL_REP];
      c_next.fen = m[`PSCEH_CTRL_FEN_LSB +: NF];
    end
    if (hit(avs_address, `PSCEH_OFF_IMASK, wr_acc))
    begin
      c_next.imask = (c_reg.imask & ~wmask[1:0]) | w1c[1:0];
    end
    // New events win over a clear in the same cycle
    if (hit(avs_address, `PSCEH_OFF_ISTAT, wr_acc))
    begin
      c_next.ist = (c_reg.ist & ~w1c[1:0]) | ev_set;
    end
    else
    begin
      c_next.ist = c_reg.ist | ev_set;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      c_reg <= '0;
      c_reg.msg_en <= `PSCEH_RST_MSG_EN;
      c_reg.ep <= `PSCEH_RST_EP;
      c_reg.rep <= `PSCEH_RST_REP;
      c_reg.fen <= '1;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  psceh_pm_handshake #(
    .NF(NF)
  ) u_pm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pmw_valid(pmw_valid),
    .pmw_ready(pmw_ready),
    .pmw_func(pmw_func),
    .pmw_is_vf(pmw_is_vf),
    .pmw_dstate(pmw_dstate),
    .pm_change_req(pm_change_req),
    .pm_change_ack(pm_change_ack),
    .pm_target_func(pm_target_func),
    .pf_dstate_out(pf_dstate_out),
    .vf_dstate_out(vf_dstate_out),
    .cpl_in_valid(cpl_in_valid),
    .cpl_in_ready(cpl_in_ready),
    .cpl_out_valid(cpl_out_valid),
    .cpl_out_ready(cpl_out_ready)
  );

  psceh_cor_err #(
    .NF(NF)
  ) u_cor (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cor_err_in(cor_err_in),
    .func_en(c_reg.fen),
    .msg_en(c_reg.msg_en),
    .ep_mode(c_reg.ep),
    .report_en(c_reg.rep),
    .aer_clr(aer_clr),
    .dev_clr(dev_clr),
    .aer_stat(aer_stat),
    .dev_stat(dev_stat),
    .cor_err_out(cor_err_out),
    .cor_msg_req(cor_msg_req),
    .cor_event(cor_event)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  port_field_a: assert property (rst_n |=> c_reg.port == $past(downstream_port_id_in))
    else $error("port number field stale");
  lcap_read_a: assert property (avs_read && !avs_waitrequest && avs_address == `PSCEH_OFF_LCAP |->
    avs_readdata[`PSCEH_LCAP_PORT_LSB +: 8] == $past(downstream_port_id_in, 2))
    else $error("link capability read wrong");
  one_wait_a: assert property (req && !c_reg.ack |=> !avs_waitrequest || !$past(req) || !req)
    else $error("bus answer late");
  pm_irq_a: assert property ($rose(pm_change_req) |=> c_reg.ist[`PSCEH_IRQ_PM])
    else $error("power request event lost");
  cor_irq_a: assert property (cor_err_in |=> ##1 c_reg.ist[`PSCEH_IRQ_COR])
    else $error("correctable event lost");
  bus_read_c: cover property (avs_read && avs_waitrequest ##1 avs_read && !avs_waitrequest);
  irq_c: cover property (!irq ##1 irq);
endmodule : psceh_core
`default_nettype wire

// File: verilog/psceh_cfg.svh
`ifndef PSCEH_CFG_SVH
`define PSCEH_CFG_SVH
`define PSCEH_OFF_CTRL 6'h00
`define PSCEH_OFF_ISTAT 6'h04
`define PSCEH_OFF_IMASK 6'h08
`define PSCEH_OFF_AER 6'h0C
`define PSCEH_OFF_DSTAT 6'h10
`define PSCEH_OFF_PM 6'h14
`define PSCEH_OFF_LCAP 6'h18
`define PSCEH_CTRL_MSG_EN 0
`define PSCEH_CTRL_EP 1
`define PSCEH_CTRL_REP 2
`define PSCEH_CTRL_FEN_LSB 8
`define PSCEH_RST_MSG_EN 1'h0
`define PSCEH_RST_EP 1'h1
`define PSCEH_RST_REP 1'h1
`define PSCEH_IRQ_PM 0
`define PSCEH_IRQ_COR 1
`define PSCEH_PM_BUSY 0
`define PSCEH_PM_VF_LSB 4
`define PSCEH_PM_TGT_LSB 8
`define PSCEH_PM_PF_LSB 16
`define PSCEH_LCAP_PORT_LSB 24
`define PSCEH_D0 2'h0
`define PSCEH_D1 2'h1
`define PSCEH_D3 2'h3
`endif

// File: verilog/psceh_pkg.sv
`default_nettype none
package psceh_pkg;
  typedef logic [1:0] psceh_dstate_t;
  typedef enum logic {PM_IDLE, PM_WAIT_ACK} psceh_pm_st_t;
endpackage : psceh_pkg
`default_nettype wire

// File: verilog/psceh_pm_handshake.sv
`timescale 1ns/1ns
`default_nettype none
`include "psceh_cfg.svh"
module psceh_pm_handshake #(
  parameter int NF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Power management control write
  input wire logic pmw_valid,
  output logic pmw_ready,
  input wire logic [7:0] pmw_func,
  input wire logic pmw_is_vf,
  input wire psceh_pkg::psceh_dstate_t pmw_dstate,
  // User handshake
  output logic pm_change_req,
  input wire logic pm_change_ack,
  output logic [7:0] pm_target_func,
  output logic [2*NF-1:0] pf_dstate_out,
  output psceh_pkg::psceh_dstate_t vf_dstate_out,
  // Completion path
  input wire logic cpl_in_valid,
  output logic cpl_in_ready,
  output logic cpl_out_valid,
  input wire logic cpl_out_ready
);
  import psceh_pkg::*;

  typedef struct packed {
    psceh_pm_st_t st;
    logic [7:0] func;
    logic is_vf;
    psceh_dstate_t dst;
    logic [2*NF-1:0] pf;
    psceh_dstate_t vf;
  } psceh_pm_state_t;

  psceh_pm_state_t pm_reg;
  psceh_pm_state_t pm_next;
  logic take;
  logic low;
  logic hold;

  function automatic psceh_pm_state_t apply_d(psceh_pm_state_t s, logic [7:0] f, logic v, psceh_dstate_t d);
    psceh_pm_state_t o;
    o = s;
    if (v)
    begin
      o.vf = d;
    end
    else
    begin
      for (int i = 0; i < NF; i++)
      begin
        if (f == 8'(i))
        begin
          o.pf[2*i +: 2] = d;
        end
      end
    end
    return o;
  endfunction : apply_d

  assign low = (pmw_dstate == `PSCEH_D1) || (pmw_dstate == `PSCEH_D3);
  assign pmw_ready = (pm_reg.st == PM_IDLE);
  assign take = pmw_valid && pmw_ready;
  // Stall from the triggering write onward
  assign hold = (pm_reg.st == PM_WAIT_ACK) || (take && low);
  assign cpl_out_valid = cpl_in_valid && !hold;
  assign cpl_in_ready = cpl_out_ready && !hold;
  assign pm_change_req = (pm_reg.st == PM_WAIT_ACK);
  assign pm_target_func = pm_reg.func;
  assign pf_dstate_out = pm_reg.pf;
  assign vf_dstate_out = pm_reg.vf;

  always_comb
  begin
    pm_next = pm_reg;
    unique case (pm_reg.st)
      PM_IDLE:
      begin
        if (take && low)
        begin
          pm_next.st = PM_WAIT_ACK;
          pm_next.func = pmw_func;
          pm_next.is_vf = pmw_is_vf;
          pm_next.dst = pmw_dstate;
        end
        else if (take)
        begin
          pm_next = apply_d(pm_reg, pmw_func, pmw_is_vf, pmw_dstate);
        end
      end
      PM_WAIT_ACK:
      begin
        // Ack tied high ends the wait after one cycle
        if (pm_change_ack)
        begin
          pm_next = apply_d(pm_reg, pm_reg.func, pm_reg.is_vf, pm_reg.dst);
          pm_next.st = PM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pm_reg <= '0;
    end
    else
    begin
      pm_reg <= pm_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  req_rise_a: assert property (take && low |=> pm_change_req && pm_target_func == $past(pmw_func))
    else $error("power request not raised");
  req_hold_a: assert property (pm_change_req && !pm_change_ack |=> pm_change_req)
    else $error("power request dropped early");
  req_drop_a: assert property (pm_change_req && pm_change_ack |=> !pm_change_req)
    else $error("power request not dropped after ack");
  cpl_stall_a: assert property (pm_change_req |-> !cpl_out_valid && !cpl_in_ready)
    else $error("completion passed during power request");
  tgt_stable_a: assert property (pm_change_req ##1 pm_change_req |-> $stable(pm_target_func))
    else $error("target function changed");
  vf_update_a: assert property (pm_change_req && pm_change_ack && pm_reg.is_vf |=> vf_dstate_out == $past(pm_reg.dst))
    else $error("vf power state not updated");
  pf_keep_a: assert property (pm_change_req && !pm_change_ack |=> $stable(pf_dstate_out))
    else $error("pf power state changed before ack");
  pm_cycle_c: cover property (take && low ##1 pm_change_req [*5] ##1 !pm_change_req);
  pm_tied_c: cover property (take && low ##1 pm_change_req && pm_change_ack ##1 !pm_change_req);
endmodule : psceh_pm_handshake
`default_nettype wire

// File: verilog/psceh_cor_err.sv
`timescale 1ns/1ns
`default_nettype none
`include "psceh_cfg.svh"
module psceh_cor_err #(
  parameter int NF = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // User error input
  input wire logic cor_err_in,
  // Controls
  input wire logic [NF-1:0] func_en,
  input wire logic msg_en,
  input wire logic ep_mode,
  input wire logic report_en,
  input wire logic [NF-1:0] aer_clr,
  input wire logic [NF-1:0] dev_clr,
  // Status and outputs
  output logic [NF-1:0] aer_stat,
  output logic [NF-1:0] dev_stat,
  output logic cor_err_out,
  output logic cor_msg_req,
  output logic cor_event
);
  import psceh_pkg::*;

  typedef struct packed {
    logic [NF-1:0] aer;
    logic [NF-1:0] dev;
    logic out;
    logic msg;
    logic evt;
  } psceh_cor_state_t;

  psceh_cor_state_t cor_reg;
  psceh_cor_state_t cor_next;
  logic [NF-1:0] aer_set;
  logic [NF-1:0] dev_set;

  // Per-function set terms
  for (genvar i = 0; i < NF; i++)
  begin : g_fn
    assign aer_set[i] = cor_err_in && func_en[i];
    assign dev_set[i] = aer_set[i] && report_en;
  end

  always_comb
  begin
    cor_next = cor_reg;
    cor_next.aer = (cor_reg.aer & ~aer_clr) | aer_set;
    cor_next.dev = (cor_reg.dev & ~dev_clr) | dev_set;
    cor_next.out = ep_mode && (|dev_set);
    cor_next.msg = cor_err_in && msg_en;
    cor_next.evt = cor_err_in;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cor_reg <= '0;
    end
    else
    begin
      cor_reg <= cor_next;
    end
  end

  assign aer_stat = cor_reg.aer;
  assign dev_stat = cor_reg.dev;
  assign cor_err_out = cor_reg.out;
  assign cor_msg_req = cor_reg.msg;
  assign cor_event = cor_reg.evt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  aer_set_a: assert property (cor_err_in |=> (aer_stat & $past(func_en)) == $past(func_en))
    else $error("aer status not set");
  msg_send_a: assert property (cor_err_in && msg_en |=> cor_msg_req)
    else $error("error message missing");
  msg_gate_a: assert property (!(cor_err_in && msg_en) |=> !cor_msg_req)
    else $error("error message without cause");
  out_cause_a: assert property (cor_err_out |-> $past(ep_mode && report_en && cor_err_in && |func_en))
    else $error("error output without cause");
  out_or_a: assert property (cor_err_out |-> |dev_stat)
    else $error("error output without status bit");
  cor_msg_c: cover property (cor_err_in && msg_en ##1 cor_msg_req);
endmodule : psceh_cor_err
`default_nettype wire

// File: bench/psceh_user_model.sv
`timescale 1ns/1ns
`default_nettype none
module psceh_user_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench commands
  input wire logic [3:0] ack_delay,
  input wire logic ack_tie,
  input wire logic cor_go,
  // Device side
  input wire logic pm_change_req,
  output logic pm_change_ack,
  output logic cor_err_in
);
  logic [3:0] wait_reg;
  logic ready_now;
  assign ready_now = pm_change_req & !pm_change_ack & (wait_reg == ack_delay);
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wait_reg <= 4'h0;
      pm_change_ack <= 1'b0;
      cor_err_in <= 1'b0;
    end
    else
    begin
      // Acknowledge one cycle once ready, or held high
      pm_change_ack <= ack_tie | ready_now;
      if (!pm_change_req)
      begin
        wait_reg <= 4'h0;
      end
      else if (!pm_change_ack && wait_reg != ack_delay)
      begin
        wait_reg <= wait_reg + 4'h1;
      end
      // Single-cycle error pulse
      cor_err_in <= cor_go;
    end
  end
endmodule : psceh_user_model
`default_nettype wire

// File: bench/tb_psceh_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "psceh_cfg.svh"
module tb_psceh_core;
  import psceh_pkg::*;
  localparam int NF = 4;
  logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, ack_delay;
  logic pmw_valid, pmw_ready, pmw_is_vf, pm_change_req, pm_change_ack, ack_tie, cor_go;
  logic [7:0] pmw_func, pm_target_func, downstream_port_id_in;
  psceh_dstate_t pmw_dstate, vf_dstate_out;
  logic [2*NF-1:0] pf_dstate_out;
  logic cpl_in_valid, cpl_in_ready, cpl_out_valid, cpl_out_ready, cor_err_in, cor_err_out, cor_msg_req;
  int n_errors, compares;

  psceh_core #(.NF(NF)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .pmw_valid(pmw_valid),
    .pmw_ready(pmw_ready), .pmw_func(pmw_func), .pmw_is_vf(pmw_is_vf), .pmw_dstate(pmw_dstate),
    .pm_change_req(pm_change_req), .pm_change_ack(pm_change_ack), .pm_target_func(pm_target_func),
    .pf_dstate_out(pf_dstate_out), .vf_dstate_out(vf_dstate_out), .cpl_in_valid(cpl_in_valid),
    .cpl_in_ready(cpl_in_ready), .cpl_out_valid(cpl_out_valid), .cpl_out_ready(cpl_out_ready),
    .downstream_port_id_in(downstream_port_id_in), .cor_err_in(cor_err_in), .cor_err_out(cor_err_out),
    .cor_msg_req(cor_msg_req));

  psceh_user_model user (.sys_clk(sys_clk), .rst_n(rst_n), .ack_delay(ack_delay), .ack_tie(ack_tie),
    .cor_go(cor_go), .pm_change_req(pm_change_req), .pm_change_ack(pm_change_ack), .cor_err_in(cor_err_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic avm(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avm

  task automatic cor_pulse;
    @(posedge sys_clk);
    cor_go <= 1'b1;
    @(posedge sys_clk);
    cor_go <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : cor_pulse

  task automatic pm_cycle(input logic [7:0] f, input logic vf, input psceh_dstate_t d, input logic [3:0] dly,
    input logic tie);
    int k, n;
    logic lowp;
    k = 0;
    n = 0;
    lowp = (d == `PSCEH_D1) || (d == `PSCEH_D3);
    @(posedge sys_clk);
    ack_delay <= dly;
    ack_tie <= tie;
    pmw_valid <= 1'b1;
    pmw_func <= f;
    pmw_is_vf <= vf;
    pmw_dstate <= d;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pmw_ready !== 1'b1 && k < 20);
    if (lowp)
    begin
      chk("cpl gated on write", 32'h0, {31'h0, cpl_out_valid});
    end
    pmw_valid <= 1'b0;
    @(posedge sys_clk);
    while (pm_change_req === 1'b1 && n < 40)
    begin
      chk("target func", {24'h0, f}, {24'h0, pm_target_func});
      chk("cpl held", 32'h0, {31'h0, cpl_out_valid});
      chk("cpl in held", 32'h0, {31'h0, cpl_in_ready});
      n++;
      @(posedge sys_clk);
    end
    chk("req cycles", lowp ? (tie ? 32'd1 : 32'(dly) + 32'd2) : 32'd0, 32'(n));
    chk("new state", {30'h0, d}, {30'h0, vf ? vf_dstate_out : pf_dstate_out[2*f[1:0] +: 2]});
    chk("cpl resumes", 32'h1, {31'h0, cpl_out_valid});
    chk("cpl in resumes", 32'h1, {31'h0, cpl_in_ready});
    ack_tie <= 1'b0;
  endtask : pm_cycle

  task automatic t_reset;
    avm(1'b0, `PSCEH_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0000_0F06, rd);
    avm(1'b0, `PSCEH_OFF_PM, 32'h0);
    chk("pm reset", 32'h0, rd);
    avm(1'b1, 6'h3C, 32'hFFFF_FFFF);
    avm(1'b0, 6'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    avm(1'b0, `PSCEH_OFF_LCAP, 32'h0);
    chk("port id", 32'hA500_0000, rd);
    downstream_port_id_in <= 8'h3C;
    avm(1'b0, `PSCEH_OFF_LCAP, 32'h0);
    chk("port id new", 32'h3C00_0000, rd);
    avs_byteenable <= 4'h2;
    avm(1'b1, `PSCEH_OFF_CTRL, 32'h0000_0001);
    avs_byteenable <= 4'hF;
    avm(1'b0, `PSCEH_OFF_CTRL, 32'h0);
    chk("ctrl lanes", 32'h0000_0006, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pm;
    pm_cycle(8'h02, 1'b0, `PSCEH_D3, 4'h3, 1'b0);
    for (int d = 0; d < 4; d++)
    begin
      pm_cycle(8'h01, 1'b0, psceh_dstate_t'(d), 4'h0, 1'b0);
    end
    pm_cycle(8'h09, 1'b1, `PSCEH_D1, 4'h0, 1'b1);
    avm(1'b0, `PSCEH_OFF_ISTAT, 32'h0);
    chk("pm event", 32'h0000_0001, rd);
    $display("test power handshake done");
  endtask : t_pm

  task automatic t_cor;
    avm(1'b1, `PSCEH_OFF_CTRL, 32'h0000_0F07);
    avm(1'b1, `PSCEH_OFF_IMASK, 32'h0000_0002);
    cor_pulse;
    chk("cor out", 32'h1, {31'h0, cor_err_out});
    chk("msg req", 32'h1, {31'h0, cor_msg_req});
    @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    avm(1'b0, `PSCEH_OFF_AER, 32'h0);
    chk("aer all", 32'h0000_000F, rd);
    avm(1'b0, `PSCEH_OFF_DSTAT, 32'h0);
    chk("dev stat", 32'h0000_000F, rd);
    avm(1'b1, `PSCEH_OFF_ISTAT, 32'h0000_0002);
    avm(1'b1, `PSCEH_OFF_AER, 32'h0000_000F);
    avm(1'b1, `PSCEH_OFF_DSTAT, 32'h0000_000F);
    chk("irq cleared", 32'h0, {31'h0, irq});
    avm(1'b1, `PSCEH_OFF_CTRL, 32'h0000_0306);
    cor_pulse;
    chk("cor out two fn", 32'h1, {31'h0, cor_err_out});
    chk("msg off", 32'h0, {31'h0, cor_msg_req});
    avm(1'b0, `PSCEH_OFF_AER, 32'h0);
    chk("aer enabled", 32'h0000_0003, rd);
    avm(1'b1, `PSCEH_OFF_DSTAT, 32'h0000_000F);
    avm(1'b1, `PSCEH_OFF_CTRL, 32'h0000_0F04);
    cor_pulse;
    chk("cor out root", 32'h0, {31'h0, cor_err_out});
    avm(1'b1, `PSCEH_OFF_DSTAT, 32'h0000_000F);
    avm(1'b1, `PSCEH_OFF_CTRL, 32'h0000_0F03);
    cor_pulse;
    chk("cor out masked", 32'h0, {31'h0, cor_err_out});
    chk("msg on", 32'h1, {31'h0, cor_msg_req});
    avm(1'b0, `PSCEH_OFF_DSTAT, 32'h0);
    chk("dev stat masked", 32'h0, rd);
    $display("test correctable error done");
  endtask : t_cor

  task automatic results;
    $display("Compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial
  begin
    n_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    pmw_valid = 1'b0;
    pmw_func = 8'h00;
    pmw_is_vf = 1'b0;
    pmw_dstate = `PSCEH_D0;
    cpl_in_valid = 1'b1;
    cpl_out_ready = 1'b1;
    downstream_port_id_in = 8'hA5;
    ack_delay = 4'h0;
    ack_tie = 1'b0;
    cor_go = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_pm;
    t_cor;
    results;
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    results;
  end
endmodule : tb_psceh_core
`default_nettype wire
